// File: logic/flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// core clock and cycle rounding
`define CLK_MHZ           200
`define NS_TO_CYC_UP(ns)  ((((ns) * `CLK_MHZ) + 999) / 1000)

// bus cycle times in ns
`define T_SETUP_NS        10
`define T_WE_PULSE_NS     50
`define T_ACCESS_NS       90
`define T_HOLD_NS         10
`define T_RECOVER_NS      20
`define T_RESET_LOW_NS    100
`define T_BUSY_SETTLE_NS  100

// derived cycle counts
`define C_SETUP           `NS_TO_CYC_UP(`T_SETUP_NS)
`define C_WE_PULSE        `NS_TO_CYC_UP(`T_WE_PULSE_NS)
`define C_ACCESS          `NS_TO_CYC_UP(`T_ACCESS_NS)
`define C_HOLD            `NS_TO_CYC_UP(`T_HOLD_NS)
`define C_RECOVER         `NS_TO_CYC_UP(`T_RECOVER_NS)
`define C_RESET_LOW       `NS_TO_CYC_UP(`T_RESET_LOW_NS)
`define C_BUSY_SETTLE     `NS_TO_CYC_UP(`T_BUSY_SETTLE_NS)

// software register offsets
`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_WDATA         8'h08
`define REG_STATUS        8'h0c
`define REG_RDATA         8'h10

// flash command codes
`define CMD_READ_ARRAY    8'hff
`define CMD_READ_ID       8'h90
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hd0
`define CMD_WRITE_SETUP   8'h40
`define CMD_WRITE_SETUP2  8'h10
`define CMD_SUSPEND       8'hb0

// status byte bit positions
`define SR_READY_BIT      7
`define SR_SUSPEND_BIT    6
`define SR_ERASE_ERR_BIT  5
`define SR_WRITE_ERR_BIT  4
`define SR_SUPPLY_ERR_BIT 3

`endif

// File: logic/flash_host_pkg.sv
package flash_host_pkg;

   typedef enum logic [2:0] {
      OP_COMMAND     = 3'b000,
      OP_READ_ARRAY  = 3'b001,
      OP_READ_STATUS = 3'b010,
      OP_READ_ID     = 3'b011,
      OP_WRITE       = 3'b100,
      OP_ERASE       = 3'b101,
      OP_RESET       = 3'b110,
      OP_RAW_READ    = 3'b111
   } op_t;

   typedef enum logic [1:0] {
      MODE_ARRAY  = 2'b00,
      MODE_STATUS = 2'b01,
      MODE_ID     = 2'b10
   } mode_t;

   typedef enum logic [2:0] {
      PH_IDLE      = 3'b000,
      PH_SETUP     = 3'b001,
      PH_STROBE    = 3'b010,
      PH_HOLD      = 3'b011,
      PH_RECOVER   = 3'b100,
      PH_SETTLE    = 3'b101,
      PH_WAIT_IDLE = 3'b110,
      PH_RESET_LOW = 3'b111
   } phase_t;

   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        powerdown_reset_n;
      logic        program_supply_high;
      logic        data_pins_oe;
      logic [7:0]  data_pins;
      logic [20:0] byte_address_pins;
   } pins_t;

endpackage

// File: logic/flash_host.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_host #(
   parameter int ADDR_W = 21
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst,
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [31:0]           o_rdata,
   input  wire logic [7:0]            i_data_pins,
   input  wire logic                  i_engine_idle_pin,
   output flash_host_pkg::pins_t      o_flash
);
   import flash_host_pkg::*;

   typedef struct packed {
      phase_t              phase;
      op_t                 op;
      logic                step;
      logic [7:0]          cnt;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          wdata;
      logic [7:0]          rdata;
      mode_t               mode;
      logic                busy;
      pins_t               pins;
      logic [31:0]         rdout;
   } state_t;

   state_t s_reg;
   state_t s_next;

   function automatic logic [7:0] cyc(input int n);
      cyc = (n < 1) ? 8'h01 : 8'(n);
   endfunction

   function automatic logic is_read_op(input op_t op);
      is_read_op = (op == OP_READ_ARRAY) || (op == OP_READ_STATUS) ||
                   (op == OP_READ_ID) || (op == OP_RAW_READ);
   endfunction

   // first cycle command byte of each operation
   function automatic logic [7:0] first_cmd(input op_t op, input logic [7:0] wd);
      case (op)
         OP_READ_ARRAY:  first_cmd = `CMD_READ_ARRAY;
         OP_READ_STATUS: first_cmd = `CMD_READ_STATUS;
         OP_READ_ID:     first_cmd = `CMD_READ_ID;
         OP_WRITE:       first_cmd = `CMD_WRITE_SETUP;
         OP_ERASE:       first_cmd = `CMD_ERASE_SETUP;
         default:        first_cmd = wd;
      endcase
   endfunction

   // read mode the flash enters after a command byte
   function automatic mode_t mode_after(input logic [7:0] cmd, input mode_t cur);
      case (cmd)
         `CMD_READ_ARRAY:  mode_after = MODE_ARRAY;
         `CMD_READ_STATUS: mode_after = MODE_STATUS;
         `CMD_READ_ID:     mode_after = MODE_ID;
         `CMD_SUSPEND:     mode_after = MODE_STATUS;
         `CMD_CONFIRM:     mode_after = MODE_STATUS;
         default:          mode_after = cur;
      endcase
   endfunction

   always_comb begin
      s_next = s_reg;
      s_next.rdout = 32'h0000_0000;
      if (s_reg.cnt != 8'h00) begin
         s_next.cnt = s_reg.cnt - 8'h01;
      end
      if (i_rd) begin
         case (i_addr)
            `REG_CTRL:   s_next.rdout = {29'h0, s_reg.op};
            `REG_ADDR:   s_next.rdout = {{(32 - ADDR_W){1'b0}}, s_reg.addr};
            `REG_WDATA:  s_next.rdout = {24'h0, s_reg.wdata};
            `REG_STATUS: s_next.rdout = {26'h0, s_reg.mode, s_reg.pins.program_supply_high,
                                         s_reg.pins.powerdown_reset_n, i_engine_idle_pin, s_reg.busy};
            `REG_RDATA:  s_next.rdout = {24'h0, s_reg.rdata};
            default:     s_next.rdout = 32'h0000_0000;
         endcase
      end
      if (i_wr && !s_reg.busy) begin
         case (i_addr)
            `REG_ADDR:  s_next.addr = i_wdata[ADDR_W-1:0];
            `REG_WDATA: s_next.wdata = i_wdata[7:0];
            `REG_CTRL: begin
               s_next.op = op_t'(i_wdata[2:0]);
               s_next.busy = 1'b1;
               s_next.step = (op_t'(i_wdata[2:0]) == OP_RAW_READ) ||
                             ((op_t'(i_wdata[2:0]) == OP_READ_ARRAY) && (s_reg.mode == MODE_ARRAY));
               if (op_t'(i_wdata[2:0]) == OP_RESET) begin
                  s_next.phase = PH_RESET_LOW;
                  s_next.cnt = cyc(`C_RESET_LOW);
                  s_next.pins.powerdown_reset_n = 1'b0;
               end else begin
                  s_next.phase = PH_SETUP;
                  s_next.cnt = cyc(`C_SETUP);
               end
            end
            default: ;
         endcase
      end
      case (s_reg.phase)
         PH_IDLE: ;
         PH_SETUP: begin
            s_next.pins.ce_n = 1'b0;
            s_next.pins.byte_address_pins = s_reg.addr;
            if (s_reg.step && is_read_op(s_reg.op)) begin
               s_next.pins.data_pins_oe = 1'b0;
            end else begin
               s_next.pins.data_pins_oe = 1'b1;
               s_next.pins.data_pins = s_reg.step ?
                  ((s_reg.op == OP_ERASE) ? `CMD_CONFIRM : s_reg.wdata) : first_cmd(s_reg.op, s_reg.wdata);
               // supply high for data and confirm
               s_next.pins.program_supply_high = s_reg.step;
            end
            if (s_reg.cnt == 8'h01) begin
               s_next.phase = PH_STROBE;
               if (s_reg.step && is_read_op(s_reg.op)) begin
                  s_next.pins.oe_n = 1'b0;
                  s_next.cnt = cyc(`C_ACCESS);
               end else begin
                  s_next.pins.we_n = 1'b0;
                  s_next.cnt = cyc(`C_WE_PULSE);
               end
            end
         end
         PH_STROBE: begin
            if (s_reg.cnt == 8'h01) begin
               s_next.pins.we_n = 1'b1;
               s_next.pins.oe_n = 1'b1;
               s_next.phase = PH_HOLD;
               s_next.cnt = cyc(`C_HOLD);
               if (!s_reg.pins.oe_n) begin
                  s_next.rdata = i_data_pins;
               end
            end
         end
         PH_HOLD: begin
            if (s_reg.cnt == 8'h01) begin
               s_next.pins.ce_n = 1'b1;
               s_next.pins.data_pins_oe = 1'b0;
               s_next.phase = PH_RECOVER;
               s_next.cnt = cyc(`C_RECOVER);
               if (!s_reg.step || !is_read_op(s_reg.op)) begin
                  s_next.mode = mode_after(s_reg.pins.data_pins, s_reg.mode);
               end
            end
         end
         PH_RECOVER: begin
            if (s_reg.cnt == 8'h01) begin
               if (!s_reg.step && s_reg.op != OP_COMMAND) begin
                  s_next.step = 1'b1;
                  s_next.phase = PH_SETUP;
                  s_next.cnt = cyc(`C_SETUP);
               end else if (s_reg.step && (s_reg.op == OP_WRITE || s_reg.op == OP_ERASE)) begin
                  s_next.phase = PH_SETTLE;
                  s_next.cnt = cyc(`C_BUSY_SETTLE);
               end else begin
                  s_next.phase = PH_IDLE;
                  s_next.busy = 1'b0;
               end
            end
         end
         PH_SETTLE: begin
            if (s_reg.cnt == 8'h01) begin
               s_next.phase = PH_WAIT_IDLE;
            end
         end
         PH_WAIT_IDLE: begin
            // engine idle pin ends the job
            if (i_engine_idle_pin) begin
               s_next.pins.program_supply_high = 1'b0;
               s_next.mode = MODE_STATUS;
               s_next.phase = PH_IDLE;
               s_next.busy = 1'b0;
            end
         end
         PH_RESET_LOW: begin
            if (s_reg.cnt == 8'h01) begin
               s_next.pins.powerdown_reset_n = 1'b1;
               s_next.mode = MODE_ARRAY;
               s_next.phase = PH_RECOVER;
               s_next.step = 1'b1;
               s_next.cnt = cyc(`C_RECOVER);
            end
         end
         default: s_next.phase = PH_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_reg <= '{phase: PH_IDLE, op: OP_COMMAND, step: 1'b0, cnt: 8'h00, addr: '0,
                    wdata: 8'h00, rdata: 8'h00, mode: MODE_ARRAY, busy: 1'b0,
                    pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, powerdown_reset_n: 1'b1,
                            program_supply_high: 1'b0, data_pins_oe: 1'b0, data_pins: 8'h00,
                            byte_address_pins: 21'h000000},
                    rdout: 32'h0000_0000};
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata = s_reg.rdout;
   assign o_flash = s_reg.pins;

endmodule

// File: sim/flash_host_checker.sv
`timescale 1ns/1ps
module flash_host_checker (
   input wire logic                  i_core_clk,
   input wire logic                  i_rst,
   input wire logic [7:0]            i_addr,
   input wire logic [31:0]           i_wdata,
   input wire logic                  i_wr,
   input wire logic                  i_rd,
   input wire logic [31:0]           o_rdata,
   input wire logic [7:0]            i_data_pins,
   input wire logic                  i_engine_idle_pin,
   input wire flash_host_pkg::pins_t o_flash
);
   import flash_host_pkg::*;
   pins_t f;
   assign f = o_flash;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   a_rdata_answer: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside answer");
   a_strobe_clash: assert property (!(!f.we_n && !f.oe_n)) else $error("both strobes low");
   a_strobe_ce: assert property ((!f.we_n || !f.oe_n) |-> !f.ce_n) else $error("strobe without select");
   a_drive_read: assert property (f.data_pins_oe |-> f.oe_n) else $error("host drives while reading");
   a_we_pulse: assert property ($fell(f.we_n) |-> !f.we_n [*8] ##1 !f.we_n ##1 !f.we_n ##1 f.we_n)
      else $error("write pulse length wrong");
   a_cmd_held: assert property (!f.we_n |-> $stable(f.data_pins) && $stable(f.byte_address_pins))
      else $error("command not held");
   a_latch_edge: assert property ($rose(f.we_n) |-> !f.ce_n && f.data_pins_oe && $stable(f.data_pins))
      else $error("data gone at write edge");
   a_oe_hold: assert property ($fell(f.oe_n) |-> (!f.oe_n && $stable(f.byte_address_pins)) [*8])
      else $error("read pulse too short");
   a_supply_busy: assert property (f.program_supply_high && !i_engine_idle_pin |=> f.program_supply_high)
      else $error("supply dropped while busy");
   a_reset_pulse: assert property ($fell(f.powerdown_reset_n) |-> (!f.powerdown_reset_n && f.ce_n) [*8])
      else $error("reset pulse too short");
endmodule
bind flash_host flash_host_checker u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_pins(i_data_pins),
   .i_engine_idle_pin(i_engine_idle_pin), .o_flash(o_flash));

// File: sim/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
   parameter logic [7:0] PART_ID  = 8'h5a, // arbitrary value
   parameter int         BUSY_CYC = 40
) (
   input  wire logic                  i_core_clk,
   input  wire flash_host_pkg::pins_t i_pins,
   output logic [7:0]                 o_data_pins,
   output logic                       o_engine_idle_pin
);
   import flash_host_pkg::*;
   pins_t      prev_reg;
   mode_t      mode_reg = MODE_ARRAY;
   logic [1:0] setup_reg = 2'd0;
   logic [7:0] sr_reg = 8'h80;
   logic [7:0] lat_reg = 8'h00;
   logic [7:0] mem_reg [16] = '{default: 8'hff};
   int         busy_reg = 0;
   logic [7:0] d;
   logic [7:0] rval;
   logic [3:0] a;
   assign d = prev_reg.data_pins;
   assign a = i_pins.byte_address_pins[3:0];
   assign rval = (mode_reg == MODE_ID) ? (a[0] ? PART_ID : MAKER_ID) : (mode_reg == MODE_STATUS) ? sr_reg : mem_reg[a];
   assign o_data_pins = (i_pins.ce_n || i_pins.oe_n) ? ~lat_reg : (mode_reg == MODE_ARRAY) ? mem_reg[a] : lat_reg;
   assign o_engine_idle_pin = (busy_reg == 0);
   always @(posedge i_core_clk) begin
      prev_reg <= i_pins;
      if (!i_pins.ce_n && !i_pins.oe_n && (prev_reg.ce_n || prev_reg.oe_n)) begin
         lat_reg <= rval;
      end
      if (busy_reg > 1) begin
         busy_reg <= busy_reg - 1;
      end
      if (busy_reg == 1) begin
         busy_reg <= 0;
         sr_reg[7] <= 1'b1;
      end
      if (!prev_reg.we_n && i_pins.we_n && !prev_reg.ce_n) begin
         if (setup_reg == 2'd1) begin
            mem_reg[a] <= mem_reg[a] & d;
            sr_reg[3] <= sr_reg[3] | !prev_reg.program_supply_high;
         end
         if (setup_reg == 2'd2 && d == 8'hd0 && i_pins.byte_address_pins[20:16] == 5'h00) begin
            mem_reg <= '{default: 8'hff};
         end
         if (setup_reg != 2'd0) begin
            busy_reg <= BUSY_CYC;
            sr_reg[7] <= 1'b0;
            mode_reg <= MODE_STATUS;
            setup_reg <= 2'd0;
         end else if (busy_reg == 0) begin
            case (d)
               8'hff: mode_reg <= MODE_ARRAY;
               8'h90: mode_reg <= MODE_ID;
               8'h70: mode_reg <= MODE_STATUS;
               8'h50: sr_reg[5:3] <= 3'b000;
               8'h40, 8'h10: setup_reg <= 2'd1;
               8'h20: setup_reg <= 2'd2;
               // suspend and resume leave reads on status
               8'hb0, 8'hd0: mode_reg <= MODE_STATUS;
               default: ;
            endcase
         end
      end
      if (!i_pins.powerdown_reset_n) begin
         mode_reg <= MODE_ARRAY;
         sr_reg <= 8'h80;
         setup_reg <= 2'd0;
         busy_reg <= 0;
      end
   end
endmodule

// File: sim/parallel_flash_command_read_path_test.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"
module parallel_flash_command_read_path_test;
   import flash_host_pkg::*;
   localparam logic [7:0] MAKER_ID = 8'h3c; // arbitrary value
   localparam logic [7:0] PART_ID  = 8'h5a; // arbitrary value
   typedef struct packed {logic [2:0] op; logic [20:0] adr; logic [7:0] dat; logic chk; logic [7:0] exp;} row_t;
   logic        i_core_clk, i_rst, i_wr, i_rd, i_engine_idle_pin;
   logic [7:0]  i_addr, i_data_pins, dq_model;
   logic [31:0] i_wdata, o_rdata, v;
   pins_t       o_flash;
   int          err_total, check_count;
   row_t rows [18] = '{
      '{3'd1, 21'h3, 8'h00, 1'b1, 8'hff},
      '{3'd4, 21'h3, 8'h5a, 1'b0, 8'h00},
      '{3'd1, 21'h3, 8'h00, 1'b1, 8'h5a},
      '{3'd4, 21'h3, 8'hf0, 1'b0, 8'h00},
      '{3'd1, 21'h3, 8'h00, 1'b1, 8'h50},
      '{3'd2, 21'h0, 8'h00, 1'b1, 8'h80},
      '{3'd3, 21'h0, 8'h00, 1'b1, MAKER_ID},
      '{3'd3, 21'h1, 8'h00, 1'b1, PART_ID},
      '{3'd5, 21'h0, 8'h00, 1'b0, 8'h00},
      '{3'd1, 21'h3, 8'h00, 1'b1, 8'hff},
      '{3'd0, 21'h0, 8'h90, 1'b0, 8'h00},
      '{3'd6, 21'h0, 8'h00, 1'b0, 8'h00},
      '{3'd7, 21'h3, 8'h00, 1'b1, 8'hff},
      '{3'd0, 21'h0, 8'hb0, 1'b0, 8'h00},
      '{3'd7, 21'h3, 8'h00, 1'b1, 8'h80},
      '{3'd0, 21'h0, 8'h70, 1'b0, 8'h00},
      '{3'd0, 21'h0, 8'h00, 1'b0, 8'h00},
      '{3'd7, 21'h3, 8'h00, 1'b1, 8'h80}};
   assign i_data_pins = o_flash.data_pins_oe ? o_flash.data_pins : dq_model;
   flash_host u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_pins(i_data_pins),
      .i_engine_idle_pin(i_engine_idle_pin), .o_flash(o_flash));
   flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .BUSY_CYC(40)) u_model (.i_core_clk(i_core_clk),
      .i_pins(o_flash), .o_data_pins(dq_model), .o_engine_idle_pin(i_engine_idle_pin));
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic wait_idle();
      logic [31:0] s;
      for (int n = 0; n < 2000; n++) begin
         rd(`REG_STATUS, s);
         if (s[0] === 1'b0) return;
      end
      chk("busy timeout", 32'h0, 32'h1);
      stop_test();
   endtask
   task automatic run_op(input row_t r);
      wr(`REG_ADDR, {11'h0, r.adr});
      wr(`REG_WDATA, {24'h0, r.dat});
      wr(`REG_CTRL, {29'h0, r.op});
      wait_idle();
   endtask
   initial begin
      {i_wr, i_rd, i_addr, i_wdata, err_total, check_count} = '0;
      i_rst = 1'b1;
      repeat (12) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd(`REG_STATUS, v);
      chk("status after reset", 32'h06, v);
      rd(8'h20, v);
      chk("unmapped read", 32'h0, v);
      $display("test reset done");
      foreach (rows[k]) begin
         run_op(rows[k]);
         if (rows[k].chk) begin
            rd(`REG_RDATA, v);
            chk($sformatf("row %0d", k), {24'h0, rows[k].exp}, v);
         end
      end
      $display("test rows done");
      wr(`REG_ADDR, 32'h5);
      wr(`REG_WDATA, 32'h0f);
      wr(`REG_CTRL, 32'h4);
      wr(`REG_ADDR, 32'h7);
      v = 32'h2;
      for (int n = 0; n < 200 && v[1] !== 1'b0; n++) rd(`REG_STATUS, v);
      chk("idle pin while busy", 32'h0, {31'h0, v[1]});
      wait_idle();
      rd(`REG_STATUS, v);
      chk("status after write", 32'h16, v);
      rd(`REG_ADDR, v);
      chk("addr kept while busy", 32'h5, v);
      run_op('{3'd7, 21'h9, 8'h00, 1'b1, 8'h80});
      rd(`REG_RDATA, v);
      chk("read after write", 32'h80, v);
      $display("test busy done");
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd(`REG_STATUS, v);
      chk("status after mid reset", 32'h06, v);
      rd(`REG_CTRL, v);
      chk("ctrl after mid reset", 32'h0, v);
      $display("test mid reset done");
      stop_test();
   end
endmodule
